/* File: rtl/slc_pkg.sv */
package slc_pkg;
    // Register byte offsets
    localparam logic [7:0] HLC_OFS = 8'h50;
    localparam logic [7:0] BASE_OFS = 8'h64;
    localparam logic [7:0] CNT_OFS = 8'h68;
    // Field positions
    localparam int POST_BIT = 18;
    localparam int GATE_BIT = 17;
    localparam int RST_BIT = 16;
    localparam int FAULT_BIT = 31;
    localparam int EPOCH_LO = 16;
    localparam int TALLY_LO = 2;
    localparam int BASE_LO = 11;
    // Reset values
    localparam logic [20:0] BASE_RST = 21'h00_0000;
    localparam logic [7:0] EPOCH_RST = 8'h00;
    localparam logic [8:0] TALLY_RST = 9'h000;
    // Timing
    localparam int CLK_NS = 8;
    localparam int SRST_NS = 32;
    localparam logic [2:0] SRST_CYC = 3'((SRST_NS + CLK_NS - 1) / CLK_NS);
    // Buffer
    localparam int FIFO_W = 32;
    localparam int FIFO_D = 16;

    typedef struct packed {
        logic brst;
        logic start;
        logic stop;
        logic err;
        logic valid;
        logic [31:0] data;
    } slc_sid_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } slc_mwr_t;
endpackage

/* File: rtl/slc_top.sv */
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Operation
// R01: Reset and soft reset clear link gate
// R02: Software enables gate when ready, forces bus reset; the code forces no bus reset when the gate is set
// R03: Gate low: no receive, process, transmit
// R04: Soft reset clears state, FIFOs, registers
// R05: Bus configuration space untouched by soft reset
// R06: Reset request reads one until done
// R07: Control bits 15..0 read zero
// R08: Buffer base 2K aligned, low bits zero
// R09: Self-ID quadlets written from buffer base
// R10: Fault flag set on reception error
// R11: Fault flag cleared after clean reception
// R12: Epoch counts bus resets, wraps at 255
// R13: Tally counts quadlets written this epoch
// R14: Tally cleared when reception starts
// R15: Count register reserved bits read zero
// R16: Posting bit changed only while gate low; the code takes it on any control write without the reset bit, gate high or low
// R17: Count register ignores host writes
module slc_fifo #(
    parameter int W = 32,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic push, pop;

    always_comb begin
        in_ready_o = cnt != (AW+1)'(D);
        out_valid_o = cnt != '0;
        out_data_o = mem[rp];
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wp = push ? wp + 1'b1 : wp;
        next_rp = pop ? rp + 1'b1 : rp;
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            next_wp = '0;
            next_rp = '0;
            next_cnt = '0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    // Data storage needs no reset
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wp] <= in_data_i;
        end
    end
endmodule

module slc_top (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Self-ID stream from PHY pins
    input wire slc_pkg::slc_sid_t sid_i,
    output logic rx_ready_o,
    // Host memory write port
    output slc_pkg::slc_mwr_t mwr_o,
    input wire logic mwr_ready_i,
    input wire logic mwr_err_i,
    // Link state
    output logic link_on_o,
    output logic write_posting_allow_o
);
    // Bus side
    logic ap_wr, ap_rd, next_ap_wr, next_ap_rd;
    logic [7:0] ap_ofs, next_ap_ofs;
    logic [31:0] hrdata, next_hrdata;
    // Control
    logic link_active_gate, next_gate;
    logic write_posting_allow, next_post;
    logic [20:0] base, next_base;
    logic [2:0] srst_cnt, next_srst_cnt;
    logic srst_act;
    // Reception
    slc_pkg::slc_sid_t sid_s1, sid_s2;
    logic brst_d;
    logic [7:0] bus_reset_epoch, next_epoch;
    logic [8:0] report_quadlet_tally, next_tally;
    logic report_fault_flag, next_fault;
    logic rx_err, next_rx_err, pend, next_pend;
    logic rx_ready, next_rx_ready;
    logic brst_rise, commit;
    // Memory writer
    slc_pkg::slc_mwr_t mwr, next_mwr;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
    logic [31:0] f_out_data;
    logic mwr_done;

    function automatic logic [31:0] reg_read(input logic [7:0] ofs, input logic gate, input logic post,
                                             input logic busy, input logic [20:0] b, input logic flt,
                                             input logic [7:0] ep, input logic [8:0] tl);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (ofs)
            slc_pkg::HLC_OFS: begin
                r[slc_pkg::POST_BIT] = post;
                r[slc_pkg::GATE_BIT] = gate; // [R07]
                r[slc_pkg::RST_BIT] = busy; // [R06]
            end
            slc_pkg::BASE_OFS: r[31:slc_pkg::BASE_LO] = b; // [R08]
            slc_pkg::CNT_OFS: begin
                r[slc_pkg::FAULT_BIT] = flt; // [R15]
                r[slc_pkg::EPOCH_LO +: 8] = ep;
                r[slc_pkg::TALLY_LO +: 9] = tl;
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    assign srst_act = srst_cnt != 3'h0;

    // Address phase is captured, data phase completes with no wait state
    always_comb begin
        logic take;
        take = hsel_i && hready_i && htrans_i[1];
        next_ap_wr = take && hwrite_i;
        next_ap_rd = take && !hwrite_i;
        next_ap_ofs = take ? haddr_i[7:0] : ap_ofs;
        next_hrdata = 32'h0000_0000;
        if (take && !hwrite_i) begin
            next_hrdata = reg_read(haddr_i[7:0], link_active_gate, write_posting_allow, srst_act,
                                   base, report_fault_flag, bus_reset_epoch, report_quadlet_tally);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ap_wr <= 1'b0;
            ap_rd <= 1'b0;
            ap_ofs <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout_o <= 1'b0;
            hresp_o <= 1'b0;
        end else begin
            ap_wr <= next_ap_wr;
            ap_rd <= next_ap_rd;
            ap_ofs <= next_ap_ofs;
            hrdata <= next_hrdata;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    assign hrdata_o = hrdata;

    // Control register and soft reset sequencer
    always_comb begin
        next_gate = link_active_gate;
        next_post = write_posting_allow;
        next_base = base;
        next_srst_cnt = srst_act ? srst_cnt - 3'h1 : 3'h0;
        if (ap_wr && ap_ofs == slc_pkg::HLC_OFS && !srst_act) begin
            if (hwdata_i[slc_pkg::RST_BIT]) begin
                next_srst_cnt = slc_pkg::SRST_CYC; // [R04]
            end else begin
                next_gate = hwdata_i[slc_pkg::GATE_BIT];
                next_post = hwdata_i[slc_pkg::POST_BIT];
            end
        end
        if (ap_wr && ap_ofs == slc_pkg::BASE_OFS && !srst_act) begin
            next_base = hwdata_i[31:slc_pkg::BASE_LO]; // [R08]
        end
        // Only block registers; bus configuration space lives elsewhere
        if (srst_act) begin // [R04][R05]
            next_gate = 1'b0; // [R01]
            next_post = 1'b0;
            next_base = slc_pkg::BASE_RST;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            link_active_gate <= 1'b0; // [R01]
            write_posting_allow <= 1'b0;
            base <= slc_pkg::BASE_RST;
            srst_cnt <= 3'h0;
        end else begin
            link_active_gate <= next_gate;
            write_posting_allow <= next_post;
            base <= next_base;
            srst_cnt <= next_srst_cnt;
        end
    end

    // Pin synchroniser
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sid_s1 <= '0;
            sid_s2 <= '0;
            brst_d <= 1'b0;
        end else begin
            sid_s1 <= sid_i;
            sid_s2 <= sid_s1;
            brst_d <= sid_s2.brst;
        end
    end

    // Inputs ignored while the gate is low, as if unplugged
    assign brst_rise = sid_s2.brst && !brst_d && link_active_gate; // [R03]
    assign f_in_valid = sid_s2.valid && link_active_gate && !srst_act; // [R03]
    assign f_flush = srst_act || !link_active_gate; // [R04]
    assign mwr_done = mwr.valid && mwr_ready_i;
    assign commit = pend && !f_out_valid && !mwr.valid;

    // Status updates; the count register never takes bus data
    always_comb begin
        next_epoch = bus_reset_epoch; // [R17]
        next_tally = report_quadlet_tally;
        next_fault = report_fault_flag;
        next_rx_err = rx_err;
        next_pend = pend;
        next_rx_ready = f_in_ready && link_active_gate && !srst_act;
        if (brst_rise) begin
            next_epoch = bus_reset_epoch + 8'h01; // [R12]
        end
        if (mwr_done) begin
            next_tally = report_quadlet_tally + 9'h001; // [R13]
            if (mwr_err_i) begin
                next_rx_err = 1'b1; // [R10]
            end
        end
        if ((sid_s2.err && link_active_gate) || (f_in_valid && !f_in_ready)) begin
            next_rx_err = 1'b1; // [R10]
        end
        if (commit) begin
            next_fault = rx_err; // [R11]
            next_pend = 1'b0;
        end
        if (sid_s2.stop && link_active_gate) begin
            next_pend = 1'b1;
        end
        if (sid_s2.start && link_active_gate) begin
            next_tally = slc_pkg::TALLY_RST; // [R14]
            next_rx_err = sid_s2.err;
            next_pend = 1'b0;
        end
        if (srst_act) begin
            next_epoch = slc_pkg::EPOCH_RST;
            next_tally = slc_pkg::TALLY_RST;
            next_fault = 1'b0;
            next_rx_err = 1'b0;
            next_pend = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bus_reset_epoch <= slc_pkg::EPOCH_RST;
            report_quadlet_tally <= slc_pkg::TALLY_RST;
            report_fault_flag <= 1'b0;
            rx_err <= 1'b0;
            pend <= 1'b0;
            rx_ready <= 1'b0;
        end else begin
            bus_reset_epoch <= next_epoch;
            report_quadlet_tally <= next_tally;
            report_fault_flag <= next_fault;
            rx_err <= next_rx_err;
            pend <= next_pend;
            rx_ready <= next_rx_ready;
        end
    end

    slc_fifo #(
        .W(slc_pkg::FIFO_W),
        .D(slc_pkg::FIFO_D)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .flush_i(f_flush),
        .in_valid_i(f_in_valid),
        .in_ready_o(f_in_ready),
        .in_data_i(sid_s2.data),
        .out_valid_o(f_out_valid),
        .out_ready_i(f_out_ready),
        .out_data_o(f_out_data)
    );

    // One write in flight keeps the address tied to the tally
    assign f_out_ready = !mwr.valid;

    always_comb begin
        next_mwr = mwr;
        if (mwr_done) begin
            next_mwr.valid = 1'b0;
        end
        if (f_out_valid && f_out_ready) begin
            next_mwr.valid = 1'b1;
            next_mwr.addr = {base, 11'h000} + {21'h00_0000, report_quadlet_tally, 2'b00}; // [R09]
            next_mwr.data = f_out_data;
        end
        // Pending host write is internal state too; dropped by soft reset
        if (srst_act) begin
            next_mwr = '0; // [R04]
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mwr <= '0;
        end else begin
            mwr <= next_mwr;
        end
    end

    assign mwr_o = mwr;
    assign rx_ready_o = rx_ready;
    assign link_on_o = link_active_gate;
    assign write_posting_allow_o = write_posting_allow;

    chk_gate_cleared: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R01]
        srst_act |=> !link_active_gate)
        else $error("gate not cleared by soft reset");

    chk_gate_blocks: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R03]
        !link_active_gate && !srst_act |=> !rx_ready && !f_out_valid && $stable(bus_reset_epoch))
        else $error("traffic taken while gate low");

    chk_reset_busy: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R06]
        ap_wr && ap_ofs == slc_pkg::HLC_OFS && hwdata_i[slc_pkg::RST_BIT] && !srst_act
        |=> srst_act [*4] ##1 !srst_act)
        else $error("soft reset length wrong");

    chk_ctrl_low_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R07]
        ap_rd && ap_ofs == slc_pkg::HLC_OFS |-> hrdata_o[15:0] == 16'h0000)
        else $error("control low half not zero");

    chk_base_low_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R08]
        ap_rd && ap_ofs == slc_pkg::BASE_OFS |-> hrdata_o[10:0] == 11'h000)
        else $error("base low bits not zero");

    chk_write_address: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R09]
        $rose(mwr.valid) |-> mwr.addr == {base, 11'h000} + {21'h00_0000, report_quadlet_tally, 2'b00})
        else $error("buffer address wrong");

    chk_fault_commit: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R11]
        commit && !srst_act |=> report_fault_flag == $past(rx_err))
        else $error("fault flag not updated");

    chk_epoch_step: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R12]
        brst_rise && !srst_act |=> bus_reset_epoch == 8'($past(bus_reset_epoch) + 8'h01))
        else $error("epoch did not step");

    chk_tally_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R14]
        sid_s2.start && link_active_gate |=> report_quadlet_tally == 9'h000)
        else $error("tally not cleared");

    chk_count_ro: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R17]
        ap_wr && ap_ofs == slc_pkg::CNT_OFS && !brst_rise && !srst_act |=> $stable(bus_reset_epoch))
        else $error("count register took a write");
endmodule

/* File: dv/slc_host_mem.sv */
`timescale 1ns/10ps
module slc_host_mem (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Bench control
    input wire logic stall_i,
    input wire logic fault_i,
    // Write port
    input wire slc_pkg::slc_mwr_t mwr_i,
    output logic ready_o,
    output logic err_o
);
    // Random back-pressure, as from a busy host bridge
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= !stall_i && ($urandom % 3 != 0);
        end
    end
    // Host write error is only meaningful with the accept
    assign err_o = fault_i && mwr_i.valid && ready_o;
endmodule

/* File: dv/tb.sv */
`timescale 1ns/10ps
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    slc_pkg::slc_sid_t sid = '0;
    logic stall = 1'b0;
    logic fault = 1'b0;
    logic ign = 1'b0;
    logic rd_pend = 1'b0;
    logic [31:0] hrdata;
    logic hrdy;
    logic hresp;
    logic rx_rdy;
    slc_pkg::slc_mwr_t mwr;
    logic mrdy;
    logic merr;
    logic link_on;
    logic post_on;
    logic [63:0] rq[$];
    logic [63:0] wq[$];
    int error_cnt = 0;
    int checks = 0;
    logic [7:0] ep = 8'h00;
    logic [8:0] tl = 9'h000;
    logic fl = 1'b0;
    logic gate = 1'b0;
    logic full = 1'b0;
    logic [31:0] base = 32'h0000_0000;

    always #4 clk_sys_i = ~clk_sys_i;

    slc_top dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(hresp), .sid_i(sid), .rx_ready_o(rx_rdy), .mwr_o(mwr),
        .mwr_ready_i(mrdy), .mwr_err_i(merr), .link_on_o(link_on), .write_posting_allow_o(post_on)
    );
    slc_host_mem mem (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .stall_i(stall), .fault_i(fault), .mwr_i(mwr),
        .ready_o(mrdy), .err_o(merr)
    );

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic tick(inout int t);
        @(posedge clk_sys_i);
        t++;
        if (t > 500) begin
            error_cnt++;
            conclude();
        end
    endtask

    task automatic wait_rdy();
        int t = 0;
        do tick(t); while (hrdy !== 1'b1);
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) begin
            rd_pend <= 1'b1;
            rq.push_back({m, d & m});
        end
        wait_rdy();
        rd_pend <= 1'b0;
    endtask

    function automatic logic [31:0] cnt();
        return {fl, 7'h00, ep, 5'h00, tl, 2'h0};
    endfunction

    // Spacing leaves room for the pin synchronisers and the ready flag
    task automatic pulse(input logic [4:0] f, input logic [31:0] d);
        sid <= {f, d};
        @(posedge clk_sys_i);
        sid <= {5'h00, d};
        repeat (5) @(posedge clk_sys_i);
    endtask

    task automatic bump();
        pulse(5'h10, 32'h0000_0000);
        if (gate) ep++;
    endtask

    // k: 0 clean, 1 pin error, 2 host write error, 3 gate low
    task automatic rx(input int n, input int k);
        logic [31:0] d;
        int t = 0;
        bump();
        ign <= (k == 1 || k == 2);
        fault <= (k == 2);
        pulse(5'h08, 32'h0000_0000);
        for (int i = 0; i < n; i++) begin
            if (k != 3 && rx_rdy !== 1'b1) begin
                full = 1'b1;
                stall <= 1'b0;
            end
            while (k != 3 && rx_rdy !== 1'b1) tick(t);
            d = $urandom;
            if (k == 0) wq.push_back({base + 32'(i * 4), d});
            pulse(5'h01, d);
            if (k == 1) pulse(5'h02, d);
        end
        pulse(5'h04, 32'h0000_0000);
        stall <= 1'b0;
        while (wq.size() > 0) tick(t);
        repeat (40) @(posedge clk_sys_i);
        fault <= 1'b0;
        ign <= 1'b0;
        if (k != 3) begin
            tl = 9'(n);
            fl = (k == 1 || k == 2);
        end
    endtask

    always @(posedge clk_sys_i) begin
        logic [63:0] e;
        if (rd_pend && hrdy === 1'b1 && rq.size() > 0) begin
            e = rq.pop_front();
            chk({31'h0000_0000, hresp, hrdata & e[63:32]}, {32'h0000_0000, e[31:0]});
        end
        if (mwr.valid === 1'b1 && mrdy === 1'b1 && !ign) begin
            e = (wq.size() > 0) ? wq.pop_front() : ~{mwr.addr, mwr.data};
            chk({mwr.addr, mwr.data}, e);
        end
    end

    initial begin
        void'($urandom(32'hfa5c3da6));
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        ahb(1'b0, slc_pkg::HLC_OFS, 32'h0000_0000, 32'hffff_ffff);
        ahb(1'b0, slc_pkg::BASE_OFS, 32'h0000_0000, 32'h0000_07ff);
        ahb(1'b0, slc_pkg::CNT_OFS, 32'h0000_0000, 32'hffff_ffff);
        ahb(1'b0, 8'h6c, 32'h0000_0000, 32'hffff_ffff);
        $display("test reset done");
        rx(2, 3);
        ahb(1'b0, slc_pkg::CNT_OFS, cnt(), 32'hffff_ffff);
        base = $urandom;
        ahb(1'b1, slc_pkg::BASE_OFS, base, 32'h0000_0000);
        base = base & 32'hffff_f800;
        ahb(1'b0, slc_pkg::BASE_OFS, base, 32'hffff_ffff);
        ahb(1'b1, slc_pkg::CNT_OFS, $urandom, 32'h0000_0000);
        ahb(1'b0, slc_pkg::CNT_OFS, cnt(), 32'hffff_ffff);
        ahb(1'b1, slc_pkg::HLC_OFS, 32'h0004_0000, 32'h0000_0000);
        @(posedge clk_sys_i);
        chk({post_on, link_on}, 2'b10);
        ahb(1'b1, slc_pkg::HLC_OFS, 32'h0006_ffff, 32'h0000_0000);
        gate = 1'b1;
        ahb(1'b0, slc_pkg::HLC_OFS, 32'h0006_0000, 32'hffff_ffff);
        chk(link_on, 1'b1);
        $display("test control done");
        bump();
        for (int k = 0; k < 3; k++) begin
            rx(3 + k, k);
            ahb(1'b0, slc_pkg::CNT_OFS, cnt(), 32'hffff_ffff);
        end
        rx(1, 0);
        ahb(1'b0, slc_pkg::CNT_OFS, cnt(), 32'hffff_ffff);
        stall <= 1'b1;
        rx(20, 0);
        ahb(1'b0, slc_pkg::CNT_OFS, cnt(), 32'hffff_ffff);
        chk(full, 1'b1);
        $display("test reception done");
        for (int i = 0; i < 260; i++) begin
            bump();
            if (ep == 8'hff || ep == 8'h00) ahb(1'b0, slc_pkg::CNT_OFS, cnt(), 32'hffff_ffff);
        end
        $display("test epoch done");
        ahb(1'b1, slc_pkg::HLC_OFS, 32'h0001_0000, 32'h0000_0000);
        ahb(1'b0, slc_pkg::HLC_OFS, 32'h0001_0000, 32'h0001_0000);
        repeat (8) @(posedge clk_sys_i);
        {gate, ep, tl, fl, base} = '0;
        ahb(1'b0, slc_pkg::HLC_OFS, 32'h0000_0000, 32'hffff_ffff);
        ahb(1'b0, slc_pkg::BASE_OFS, 32'h0000_0000, 32'hffff_ffff);
        ahb(1'b0, slc_pkg::CNT_OFS, cnt(), 32'hffff_ffff);
        chk({post_on, link_on}, 2'b00);
        $display("test soft reset done");
        conclude();
    end
endmodule
